// ### common/alc_meas_if.sv
`timescale 1ns/1ns
`default_nettype none
// Link between the register side and the measurement scheduler.
interface alc_meas_if;
  logic arm;          // One-cycle request to launch a measurement.
  logic repeat_on;    // Repeat mode is selected.
  logic [5:0] interval; // Wait between launches in 50 ms units.
  logic done;         // Front end reports the end of an integration.
  logic start;        // One-cycle launch pulse towards the front end.
  logic cycle_end;    // One-cycle pulse after a measurement has ended.
  logic measuring;    // High while an integration is running.
  modport ctl(output arm, output repeat_on, output interval, output done,
              input start, input cycle_end, input measuring);
  modport sch(input arm, input repeat_on, input interval, input done,
              output start, output cycle_end, output measuring);
endinterface
`default_nettype wire

// ### common/alc_pkg.sv
package alc_pkg;
  // Register offsets on the device register port.
  localparam logic [7:0] ADDR_UP_HI = 8'h20;
  localparam logic [7:0] ADDR_UP_LO = 8'h21;
  localparam logic [7:0] ADDR_LO_HI = 8'h22;
  localparam logic [7:0] ADDR_LO_LO = 8'h23;
  localparam logic [7:0] ADDR_FILTER = 8'h24;
  localparam logic [7:0] ADDR_SETUP = 8'h25;
  localparam logic [7:0] ADDR_INTERVAL = 8'h26;
  localparam logic [7:0] ADDR_COMMAND = 8'h27;
  localparam logic [7:0] ADDR_STATUS = 8'h40;
  // Reset values.
  localparam logic [7:0] RST_UP = 8'hff;
  localparam logic [7:0] RST_LO = 8'h00;
  localparam logic [7:0] RST_FILTER = 8'h11;
  localparam logic [7:0] RST_SETUP = 8'h40;
  localparam logic [6:0] RST_INTERVAL = 7'h0a;
  // Field positions.
  localparam int FILT_WIN_LSB = 4;
  localparam int FILT_HIT_LSB = 0;
  localparam int SET_UNF_BIT = 7;
  localparam int SET_PHO_BIT = 6;
  localparam int SET_HYS_BIT = 5;
  localparam int SET_TRIG_BIT = 4;
  localparam int SET_RANGE_LSB = 2;
  localparam int SET_INTEG_LSB = 0;
  localparam int INTV_PWR_BIT = 6;
  localparam int INTV_VAL_LSB = 0;
  localparam int CMD_SINGLE_BIT = 0;
  localparam int CMD_REPEAT_BIT = 1;
  localparam int ST_INT_BIT = 4;
  // Longest persistence window the 4-bit field can ask for.
  localparam int HIST_LEN = 15;
  // Digital range divisor.
  localparam logic [15:0] RANGE_DIV = 16'h000a;
  // Interval unit: 50 ms at a 125 MHz clock.
  localparam int INTV_UNIT_MS = 50;
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int INTV_UNIT_CYC = INTV_UNIT_MS * CLK_FREQ_KHZ;
  // Measurement scheduler states.
  typedef enum logic [1:0] {
    ALC_IDLE = 2'b00,
    ALC_MEAS = 2'b01,
    ALC_WAIT = 2'b10
  } alc_state_t;
endpackage

// ### hdl/alc_sched.sv
`timescale 1ns/1ns
`default_nettype none
module alc_sched #(
  parameter int UNIT_CYCLES = alc_pkg::INTV_UNIT_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  alc_meas_if.sch m
);
  import alc_pkg::*;

  localparam int CW = $clog2(UNIT_CYCLES + 1);

  // Whole scheduler state in one record.
  typedef struct packed {
    alc_state_t st;
    logic [CW-1:0] tick;
    logic [5:0] units;
    logic start;
    logic fin;
  } alc_sched_t;

  localparam alc_sched_t SCH_RST = '{st: ALC_IDLE, tick: '0, units: '0,
                                     start: 1'b0, fin: 1'b0};

  alc_sched_t s_reg;
  alc_sched_t s_next;
  logic expired; // The programmed interval has run out since the launch.

  // The interval is timed from the launch, so a long integration eats into it.
  assign expired = (s_reg.units >= m.interval);

  // Next-state logic: interval timer and launch decisions.
  always_comb begin
    logic launch;
    launch = 1'b0;
    s_next = s_reg;
    s_next.start = 1'b0;
    s_next.fin = 1'b0;
    // The unit counter saturates once expired, so it cannot wrap.
    if (s_reg.tick == CW'(UNIT_CYCLES - 1)) begin
      s_next.tick = '0;
      if (!expired) begin
        s_next.units = 6'(s_reg.units + 6'h01);
      end
    end else begin
      s_next.tick = CW'(s_reg.tick + 1'b1);
    end
    case (s_reg.st)
      ALC_IDLE: begin
        launch = m.arm;
      end
      ALC_MEAS: begin
        if (m.done) begin
          s_next.fin = 1'b1;
          if (!m.repeat_on) begin
            s_next.st = ALC_IDLE;
          end else if (expired) begin
            launch = 1'b1;
          end else begin
            s_next.st = ALC_WAIT;
          end
        end
      end
      ALC_WAIT: begin
        if (!m.repeat_on) begin
          s_next.st = ALC_IDLE;
        end else if (expired || m.arm) begin
          launch = 1'b1;
        end
      end
      default: begin
        s_next.st = ALC_IDLE;
      end
    endcase
    if (launch) begin
      s_next.st = ALC_MEAS;
      s_next.start = 1'b1;
      // The launch cycle is the first tick, so a relaunch lands exactly N units on.
      s_next.tick = CW'(1);
      s_next.units = '0;
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_reg <= SCH_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign m.start = s_reg.start;
  assign m.cycle_end = s_reg.fin;
  assign m.measuring = (s_reg.st == ALC_MEAS);
endmodule
`default_nettype wire

// ### hdl/alc_top.sv
`timescale 1ns/1ns
`default_nettype none
module alc_top #(
  parameter int UNIT_CYCLES = alc_pkg::INTV_UNIT_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic bus_stop_i,
  input wire logic auto_clear_i,
  input wire logic prox_above_flag_i,
  input wire logic prox_below_flag_i,
  output logic status_read_o,
  output logic meas_start_o,
  input wire logic meas_done_i,
  input wire logic [15:0] light_raw_i,
  output logic [15:0] light_data_o,
  output logic photopic_sensor_on_o,
  output logic unfiltered_sensor_on_o,
  output logic keep_low_power_o,
  output logic analog_range_o,
  output logic [1:0] integ_sel_o,
  output logic int_pin_o
);
  import alc_pkg::*;

  // Complete register-side state kept as one record.
  typedef struct packed {
    logic [7:0] up_hi;     // Upper limit, high byte.
    logic [7:0] up_lo;     // Upper limit, low byte.
    logic [7:0] lo_hi;     // Lower limit, high byte.
    logic [7:0] lo_lo;     // Lower limit, low byte.
    logic [7:0] filt;      // Window length and hit count.
    logic [7:0] setup;     // Sensor enables, hysteresis, range, integration.
    logic [6:0] intv;      // Keep-powered bit and interval.
    logic light_single_run; // Single measurement requested or running.
    logic repeat_on;       // Repeat mode selected.
    logic pend;            // Command written, waiting for the bus stop.
    logic [HIST_LEN-1:0] hist; // Recent hit history, newest in bit 0.
    logic light_above_flag; // Light went above the upper limit.
    logic light_below_flag; // Light went below the lower limit.
    logic int_q;           // Level driven on the interrupt pin.
    logic [15:0] data;     // Last scaled photopic result.
    logic [7:0] rdata;     // Read data towards the bus.
    logic rd_pulse;        // Status register was read.
    logic pho_pwr;         // Photopic sensor power.
    logic unf_pwr;         // Unfiltered sensor power.
  } alc_top_t;

  localparam alc_top_t TOP_RST = '{
    up_hi: RST_UP,
    up_lo: RST_UP,
    lo_hi: RST_LO,
    lo_lo: RST_LO,
    filt: RST_FILTER,
    setup: RST_SETUP,
    intv: RST_INTERVAL,
    light_single_run: 1'b0,
    repeat_on: 1'b0,
    pend: 1'b0,
    hist: '0,
    light_above_flag: 1'b0,
    light_below_flag: 1'b0,
    int_q: 1'b0,
    data: '0,
    rdata: '0,
    rd_pulse: 1'b0,
    pho_pwr: 1'b0,
    unf_pwr: 1'b0
  };

  alc_top_t r_reg;
  alc_top_t r_next;

  // Link to the scheduler.
  alc_meas_if m ();

  // Decoded configuration fields.
  logic [15:0] light_upper_limit; // Assembled upper limit.
  logic [15:0] light_lower_limit; // Assembled lower limit.
  logic [3:0] win_len;            // Window length N.
  logic [3:0] hit_need;           // Required hit count M.
  logic [1:0] range_sel;          // Range code.
  logic photo_eff;                // Photopic sensor is in effect.
  logic hyst_on;                  // Hysteresis really applies.
  logic trig_up;                  // Upper limit is the trigger.
  logic keep_pwr;                 // Sensor stays powered between runs.

  // Measurement evaluation.
  logic [15:0] scaled;            // Result after digital range scaling.
  logic is_above;                 // Result is above the upper limit.
  logic is_below;                 // Result is below the lower limit.
  logic hit;                      // Result counts as a filter hit.
  logic meas_ev;                  // A photopic result has arrived.
  logic [HIST_LEN-1:0] hist_new;  // History with the new hit shifted in.
  logic [HIST_LEN-1:0] in_win;    // History bits inside the window.
  logic [3:0] hit_cnt;            // Hits inside the window.
  logic fire;                     // Persistence filter lets the hit through.
  logic rd_status;                // This cycle reads the status register.
  logic [7:0] rd_val;             // Read value selected by address.

  // Bits counted one by one; the window never exceeds the history length.
  function automatic logic [3:0] count_ones(input logic [HIST_LEN-1:0] v);
    logic [3:0] c;
    c = '0;
    for (int k = 0; k < HIST_LEN; k++) begin
      c = 4'(c + 4'(v[k]));
    end
    return c;
  endfunction

  assign light_upper_limit = {r_reg.up_hi, r_reg.up_lo};
  assign light_lower_limit = {r_reg.lo_hi, r_reg.lo_lo};
  assign win_len = r_reg.filt[FILT_WIN_LSB +: 4];
  assign hit_need = r_reg.filt[FILT_HIT_LSB +: 4];
  assign range_sel = r_reg.setup[SET_RANGE_LSB +: 2];

  // With neither sensor enabled the photopic one runs alone.
  assign photo_eff = r_reg.setup[SET_PHO_BIT] | ~r_reg.setup[SET_UNF_BIT];

  // Latched-status mode has no clearing threshold, so hysteresis is off there.
  assign hyst_on = r_reg.setup[SET_HYS_BIT] & auto_clear_i;
  assign trig_up = r_reg.setup[SET_TRIG_BIT];

  // Continuous mode also keeps the sensor up, as there is no gap to save.
  assign keep_pwr = r_reg.intv[INTV_PWR_BIT]
                    | (r_reg.repeat_on && (m.interval == 6'h00));

  // High range bit divides the count by ten; the low bit goes to the front end.
  assign scaled = range_sel[1] ? 16'(light_raw_i / RANGE_DIV) : light_raw_i;

  // Unsigned window test of the scaled photopic result.
  assign is_above = scaled > light_upper_limit;
  assign is_below = scaled < light_lower_limit;

  // Under hysteresis only the trigger limit counts as a hit.
  always_comb begin
    if (hyst_on) begin
      hit = trig_up ? is_above : is_below;
    end else begin
      hit = is_above | is_below;
    end
  end

  // Only photopic results are compared; unfiltered results never raise it.
  assign meas_ev = meas_done_i & m.measuring & photo_eff;
  assign hist_new = {r_reg.hist[HIST_LEN-2:0], hit};

  // Mask the history down to the last N results.
  for (genvar i = 0; i < HIST_LEN; i++) begin : g_win
    assign in_win[i] = hist_new[i] & (4'(i) < win_len);
  end

  assign hit_cnt = count_ones(in_win);

  // A zero in either count blocks the interrupt; N below M never fires either.
  assign fire = (hit_need != 4'h0) && (win_len != 4'h0)
                && (hit_cnt >= hit_need);

  assign rd_status = reg_rd_i && (reg_addr_i == ADDR_STATUS);

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    if (reg_addr_i == ADDR_UP_HI) begin
      rd_val = r_reg.up_hi;
    end else if (reg_addr_i == ADDR_UP_LO) begin
      rd_val = r_reg.up_lo;
    end else if (reg_addr_i == ADDR_LO_HI) begin
      rd_val = r_reg.lo_hi;
    end else if (reg_addr_i == ADDR_LO_LO) begin
      rd_val = r_reg.lo_lo;
    end else if (reg_addr_i == ADDR_FILTER) begin
      rd_val = r_reg.filt;
    end else if (reg_addr_i == ADDR_SETUP) begin
      rd_val = r_reg.setup;
    end else if (reg_addr_i == ADDR_INTERVAL) begin
      rd_val = {1'b0, r_reg.intv};
    end else if (reg_addr_i == ADDR_COMMAND) begin
      rd_val = {6'h00, r_reg.repeat_on, r_reg.light_single_run};
    end else if (reg_addr_i == ADDR_STATUS) begin
      rd_val = {3'h0, r_reg.int_q, r_reg.light_above_flag,
                r_reg.light_below_flag, prox_above_flag_i,
                prox_below_flag_i};
    end else begin
      rd_val = 8'h00;
    end
  end

  // Next-state logic for registers, flags and power.
  always_comb begin
    r_next = r_reg;
    r_next.rd_pulse = rd_status;
    if (reg_rd_i) begin
      r_next.rdata = rd_val;
    end
    // A one-shot ends its own request once the cycle is over.
    if (m.cycle_end && !r_reg.repeat_on) begin
      r_next.light_single_run = 1'b0;
    end
    // A stop after a command write launches the next cycle.
    if (r_reg.pend && bus_stop_i) begin
      r_next.pend = 1'b0;
    end
    // Register writes; the status register ignores writes.
    if (reg_wr_i) begin
      if (reg_addr_i == ADDR_UP_HI) begin
        r_next.up_hi = reg_wdata_i;
      end else if (reg_addr_i == ADDR_UP_LO) begin
        r_next.up_lo = reg_wdata_i;
      end else if (reg_addr_i == ADDR_LO_HI) begin
        r_next.lo_hi = reg_wdata_i;
      end else if (reg_addr_i == ADDR_LO_LO) begin
        r_next.lo_lo = reg_wdata_i;
      end else if (reg_addr_i == ADDR_FILTER) begin
        // New counts restart the persistence history.
        r_next.filt = reg_wdata_i;
        r_next.hist = '0;
      end else if (reg_addr_i == ADDR_SETUP) begin
        r_next.setup = reg_wdata_i;
      end else if (reg_addr_i == ADDR_INTERVAL) begin
        r_next.intv = reg_wdata_i[6:0];
      end else if (reg_addr_i == ADDR_COMMAND) begin
        // A write that lands with the cycle end wins, so the request is kept.
        r_next.light_single_run = reg_wdata_i[CMD_SINGLE_BIT];
        r_next.repeat_on = reg_wdata_i[CMD_REPEAT_BIT];
        r_next.pend = reg_wdata_i[CMD_SINGLE_BIT]
                      | reg_wdata_i[CMD_REPEAT_BIT];
      end
    end
    // Latched mode: the read clears first so that a new event still sets.
    if (rd_status && !auto_clear_i) begin
      r_next.light_above_flag = 1'b0;
      r_next.light_below_flag = 1'b0;
    end
    // Evaluate each photopic result.
    if (meas_ev) begin
      r_next.hist = hist_new;
      r_next.data = scaled;
      if (hyst_on) begin
        if (trig_up) begin
          // Upper limit sets, dropping below the lower limit clears.
          if (fire) begin
            r_next.light_above_flag = 1'b1;
          end else if (is_below) begin
            r_next.light_above_flag = 1'b0;
          end
        end else begin
          // Lower limit sets, rising above the upper limit clears.
          if (fire) begin
            r_next.light_below_flag = 1'b1;
          end else if (is_above) begin
            r_next.light_below_flag = 1'b0;
          end
        end
      end else if (auto_clear_i) begin
        // Automatic clearing: flags follow the latest filtered result.
        r_next.light_above_flag = fire & is_above;
        r_next.light_below_flag = fire & is_below;
      end else begin
        // Latched mode: flags stay until the status register is read.
        if (fire && is_above) begin
          r_next.light_above_flag = 1'b1;
        end
        if (fire && is_below) begin
          r_next.light_below_flag = 1'b1;
        end
      end
    end
    r_next.int_q = r_next.light_above_flag | r_next.light_below_flag
                   | prox_above_flag_i | prox_below_flag_i;
    // Power only while integrating unless held up between runs.
    r_next.pho_pwr = photo_eff & (m.measuring | keep_pwr);
    r_next.unf_pwr = r_reg.setup[SET_UNF_BIT]
                     & (m.measuring | keep_pwr);
  end

  // Synchronous reset brings every field to its documented value.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r_reg <= TOP_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Scheduler hookup.
  assign m.arm = r_reg.pend & bus_stop_i;
  assign m.repeat_on = r_reg.repeat_on;
  assign m.interval = r_reg.intv[INTV_VAL_LSB +: 6];
  assign m.done = meas_done_i;

  alc_sched #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_sched (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .m(m.sch)
  );

  // Outputs, all from flip-flops.
  assign reg_rdata_o = r_reg.rdata;
  assign status_read_o = r_reg.rd_pulse;
  assign meas_start_o = m.start;
  assign light_data_o = r_reg.data;
  assign photopic_sensor_on_o = r_reg.pho_pwr;
  assign unfiltered_sensor_on_o = r_reg.unf_pwr;
  assign keep_low_power_o = r_reg.intv[INTV_PWR_BIT];
  assign analog_range_o = range_sel[0];
  assign integ_sel_o = r_reg.setup[SET_INTEG_LSB +: 2];
  assign int_pin_o = r_reg.int_q;
endmodule
`default_nettype wire

// ### verif/alc_checker.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of the light control block.
module alc_checker import alc_pkg::*; #(
  parameter int UNIT_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic bus_stop_i,
  input wire logic prox_above_flag_i,
  input wire logic prox_below_flag_i,
  input wire logic status_read_o,
  input wire logic meas_start_o,
  input wire logic meas_done_i,
  input wire logic photopic_sensor_on_o,
  input wire logic unfiltered_sensor_on_o,
  input wire logic keep_low_power_o,
  input wire logic analog_range_o,
  input wire logic [1:0] integ_sel_o,
  input wire logic int_pin_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Read strobe aimed at the cause register.
  wire logic st_rd = reg_rd_i && (reg_addr_i == ADDR_STATUS);
  // Write strobes to the setup and interval registers.
  wire logic wr_set = reg_wr_i && (reg_addr_i == ADDR_SETUP);
  wire logic wr_int = reg_wr_i && (reg_addr_i == ADDR_INTERVAL);
  // Repeat mode as last written; repeat relaunches come without a bus stop.
  logic rep_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rep_q <= 1'b0;
    end else if (reg_wr_i && (reg_addr_i == ADDR_COMMAND)) begin
      rep_q <= reg_wdata_i[CMD_REPEAT_BIT];
    end
  end
  property p_start_on_stop;
    meas_start_o |-> $past(bus_stop_i) || $past(rep_q);
  endproperty
  a_start_on_stop: assert property (p_start_on_stop) else $error("launch without stop");
  property p_status_pin;
    st_rd |=> reg_rdata_o[4] == $past(int_pin_o) && reg_rdata_o[7:5] == 3'h0;
  endproperty
  a_status_pin: assert property (p_status_pin) else $error("status pin bit wrong");
  property p_read_pulse;
    st_rd |=> status_read_o;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("status read pulse missing");
  property p_read_quiet;
    !st_rd |=> !status_read_o;
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("stray status read pulse");
  property p_power_up;
    meas_start_o |=> photopic_sensor_on_o || unfiltered_sensor_on_o;
  endproperty
  a_power_up: assert property (p_power_up) else $error("no sensor powered");
  property p_int_cause;
    $rose(int_pin_o) |-> $past(meas_done_i || prox_above_flag_i || prox_below_flag_i);
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt without cause");
  property p_setup_out;
    wr_set |=> analog_range_o == $past(reg_wdata_i[2]) && integ_sel_o == $past(reg_wdata_i[1:0]);
  endproperty
  a_setup_out: assert property (p_setup_out) else $error("range or time wrong");
  property p_keep_pwr;
    wr_int |=> keep_low_power_o == $past(reg_wdata_i[6]);
  endproperty
  a_keep_pwr: assert property (p_keep_pwr) else $error("keep power bit wrong");
  property p_power_down;
    $fell(photopic_sensor_on_o) |-> $past(meas_done_i, 2) || $past(reg_wr_i, 2);
  endproperty
  a_power_down: assert property (p_power_down) else $error("power fell off time");
  c_shot: cover property (meas_start_o ##[1:20] meas_done_i);
  c_status: cover property (st_rd ##1 reg_rdata_o[4]);
  c_repeat: cover property (meas_start_o ##[2:60] meas_start_o);
endmodule
bind alc_top alc_checker #(.UNIT_CYCLES(UNIT_CYCLES)) u_chk (.clk_i, .sys_rst_i, .reg_addr_i,
  .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .bus_stop_i, .prox_above_flag_i,
  .prox_below_flag_i, .status_read_o, .meas_start_o, .meas_done_i, .photopic_sensor_on_o,
  .unfiltered_sensor_on_o, .keep_low_power_o, .analog_range_o, .integ_sel_o, .int_pin_o);
`default_nettype wire

// ### verif/alc_fe_model.sv
`timescale 1ns/1ns
`default_nettype none
// Light front end: ends an integration a set number of cycles after launch.
module alc_fe_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [3:0] delay_i,
  input wire logic [15:0] raw_i,
  output logic done_o,
  output logic [15:0] raw_o
);
  logic [3:0] cnt; // Cycles left in the running integration.
  // Outside the done cycle the count is not valid, so show its inverse.
  assign raw_o = done_o ? raw_i : ~raw_i;
  // Count down from the launch and pulse done once.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt <= 4'h0;
    end else if (start_i) begin
      cnt <= delay_i;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
    done_o <= !sys_rst_i && !start_i && cnt == 4'h1;
  end
endmodule
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import alc_pkg::*;
  localparam int UC = 20; // Short interval unit keeps repeat runs brief.
  localparam logic [7:0] RSTV [9] = '{RST_UP, RST_UP, RST_LO, RST_LO, RST_FILTER,
                                      RST_SETUP, {1'b0, RST_INTERVAL}, 8'h00, 8'h00};
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, stop = 1'b0, prox = 1'b0, rd_q = 1'b0;
  logic auto_clr = 1'b0; // Interrupt configuration: automatic clearing.
  logic [15:0] raw = 16'h0000, seed = 16'h37c1, r; // Seed 14273.
  logic [3:0] dly = 4'h2;
  logic done, mstart, int_pin;
  logic [15:0] raw_fe, ldata;
  logic [7:0] rdata;
  logic [7:0] exp_q [$]; // Expected read data, oldest first.
  int n_mismatch = 0;
  int n_compared = 0;
  always #4 clk_i = ~clk_i;
  alc_top #(.UNIT_CYCLES(UC)) u_dut (.clk_i, .sys_rst_i, .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .bus_stop_i(stop),
    .auto_clear_i(auto_clr), .prox_above_flag_i(prox), .prox_below_flag_i(1'b0),
    .status_read_o(), .meas_start_o(mstart), .meas_done_i(done), .light_raw_i(raw_fe),
    .light_data_o(ldata), .photopic_sensor_on_o(), .unfiltered_sensor_on_o(),
    .keep_low_power_o(), .analog_range_o(), .integ_sel_o(), .int_pin_o(int_pin));
  alc_fe_model u_fe (.clk_i, .sys_rst_i, .start_i(mstart), .delay_i(dly), .raw_i(raw),
    .done_o(done), .raw_o(raw_fe));
  // Prints the verdict and stops the run.
  task automatic end_sim();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Sixteen-bit xorshift for measurement counts.
  function automatic logic [15:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
  endtask
  // The read result is noted here and judged by the monitor.
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    addr = a;
    rd = 1'b1;
    exp_q.push_back(e);
    @(negedge clk_i);
    rd = 1'b0;
  endtask
  task automatic pulse_stop();
    @(negedge clk_i);
    stop = 1'b1;
    @(negedge clk_i);
    stop = 1'b0;
  endtask
  // One single-shot measurement; the wait for done is bounded.
  task automatic shot(input logic [15:0] v);
    int i;
    raw = v;
    wr_reg(ADDR_COMMAND, 8'h01);
    pulse_stop();
    for (i = 0; i < 60 && done !== 1'b1; i++) @(negedge clk_i);
    if (i == 60) begin
      n_mismatch++;
      end_sim();
    end
    repeat (3) @(negedge clk_i);
  endtask
  // Repeat run: counts launches and notes the cycle of the last one, then stops.
  task automatic count_starts(input int len, input logic [15:0] exp_n,
                              input logic [15:0] exp_last);
    int c;
    int last;
    c = 0;
    last = 0;
    wr_reg(ADDR_COMMAND, 8'h02);
    pulse_stop();
    for (int j = 1; j <= len; j++) begin
      @(negedge clk_i);
      if (mstart === 1'b1) begin
        c++;
        last = j;
      end
    end
    chk(16'(c), exp_n);
    chk(16'(last), exp_last);
    wr_reg(ADDR_COMMAND, 8'h00);
    repeat (40) @(negedge clk_i);
  endtask
  // Read data lands one cycle after the strobe is taken.
  always @(posedge clk_i) rd_q <= rd;
  always @(negedge clk_i) begin
    if (rd_q && exp_q.size() > 0) begin
      chk({8'h00, rdata}, {8'h00, exp_q.pop_front()});
    end
  end
  initial begin
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    for (int k = 0; k < 9; k++) begin
      rd_reg(k < 8 ? 8'(ADDR_UP_HI + k) : ADDR_STATUS, RSTV[k]);
    end
    rd_reg(8'h30, 8'h00);
    wr_reg(ADDR_STATUS, 8'hff);
    rd_reg(ADDR_STATUS, 8'h00);
    // The first result after reset is thrown away, as a careful host would.
    shot(16'h0000);
    wr_reg(ADDR_UP_HI, 8'h10);
    wr_reg(ADDR_UP_LO, 8'h00);
    wr_reg(ADDR_LO_LO, 8'h80);
    rd_reg(ADDR_UP_HI, 8'h10);
    r = rnd();
    shot(16'h1001 + (r & 16'h0fff));
    chk(ldata, raw);
    chk({15'h0, int_pin}, 16'h0001);
    rd_reg(ADDR_COMMAND, 8'h00);
    rd_reg(ADDR_STATUS, 8'h18);
    rd_reg(ADDR_STATUS, 8'h00);
    chk({15'h0, int_pin}, 16'h0000);
    dly = 4'h9;
    wr_reg(ADDR_SETUP, 8'h48);
    r = rnd();
    shot(r & 16'h007f);
    chk(ldata, raw / 16'd10);
    rd_reg(ADDR_STATUS, 8'h14);
    wr_reg(ADDR_SETUP, 8'h00);
    shot(16'h0080);
    chk(ldata, 16'h0080);
    rd_reg(ADDR_STATUS, 8'h00);
    shot(16'h1000);
    rd_reg(ADDR_STATUS, 8'h00);
    wr_reg(ADDR_FILTER, 8'h10);
    shot(16'hffff);
    rd_reg(ADDR_STATUS, 8'h00);
    wr_reg(ADDR_FILTER, 8'h22);
    shot(16'hfff0);
    rd_reg(ADDR_STATUS, 8'h00);
    shot(16'hfff0);
    rd_reg(ADDR_STATUS, 8'h18);
    prox = 1'b1;
    repeat (2) @(negedge clk_i);
    rd_reg(ADDR_STATUS, 8'h12);
    prox = 1'b0;
    // Hysteresis under automatic clearing: upper limit sets, lower limit clears.
    auto_clr = 1'b1;
    wr_reg(ADDR_FILTER, 8'h11);
    wr_reg(ADDR_SETUP, 8'h75);
    shot(16'h2000);
    rd_reg(ADDR_STATUS, 8'h18);
    rd_reg(ADDR_STATUS, 8'h18);
    shot(16'h0100);
    rd_reg(ADDR_STATUS, 8'h18);
    shot(16'h0010);
    rd_reg(ADDR_STATUS, 8'h00);
    auto_clr = 1'b0;
    dly = 4'h3;
    wr_reg(ADDR_INTERVAL, 8'h41);
    rd_reg(ADDR_INTERVAL, 8'h41);
    count_starts(150, 16'h0007, 16'h008c);
    wr_reg(ADDR_INTERVAL, 8'h40);
    count_starts(40, 16'h0008, 16'h0028);
    end_sim();
  end
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire
